/* hdl/stpatt_top.sv */
// Control logic of the seven-bit step attenuator
`timescale 1ns/100ps
module stpatt_top
    import stpatt_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic ser_clk_in,
    input wire logic ser_data_in,
    input wire logic latch_strobe_in,
    input wire logic interface_select_in,
    input wire logic [6:0] step_control_bits_in,
    input wire logic [2:0] board_address_pins_in,
    output logic [6:0] atten_state_out,
    output logic spare_step_out,
    output logic [2:0] active_address_out,
    output logic serial_mode_out
);

    // ----------------------------------------
    // Address decoding
    // ----------------------------------------
    // board code from bits
    function automatic logic addr_match(input logic [15:0] frame, input logic [2:0] strap);
        logic [2:0] code;
        code = frame[STPATT_ADDR_POS +: STPATT_ADDR_W];
        addr_match = (code == strap);
    endfunction

    // ----------------------------------------
    // Link domain shift register
    // ----------------------------------------
    stpatt_link_if link ();

    stpatt_shift u_shift (
        .ser_clk_in(ser_clk_in),
        .latch_strobe_in(latch_strobe_in),
        .ser_data_in(ser_data_in),
        .link(link.src)
    );

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    localparam logic [11:0] SYNC_RST = {STPATT_RST_SELECT, STPATT_RST_LATCH,
        STPATT_RST_ATTEN, STPATT_RST_ADDR};

    logic [11:0] pins_agreed;
    logic sel_agreed;
    logic latch_agreed;
    logic [6:0] step_agreed;
    logic [2:0] strap_agreed;

    stpatt_sync #(
        .W(12),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .async_in({interface_select_in, latch_strobe_in, step_control_bits_in,
            board_address_pins_in}),
        .agreed_out(pins_agreed)
    );

    assign sel_agreed = pins_agreed[11];
    assign latch_agreed = pins_agreed[10];
    assign step_agreed = pins_agreed[9:3];
    assign strap_agreed = pins_agreed[2:0];

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        stpatt_mode_t mode;
        logic latch_prev;
        logic [6:0] atten;
        logic spare;
        logic [2:0] addr;
    } stpatt_state_t;

    stpatt_state_t r;
    stpatt_state_t next_r;

    logic latch_rise;
    logic frame_match;
    stpatt_mode_t mode_now;

    assign latch_rise = latch_agreed && !r.latch_prev;
    assign frame_match = addr_match(link.word, strap_agreed);

    always_comb
    begin
        if (sel_agreed)
        begin
            mode_now = MODE_SERIAL;
        end
        else if (latch_agreed)
        begin
            mode_now = MODE_DIRECT;
        end
        else
        begin
            mode_now = MODE_LATCHED;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        if (clk_en_in)
        begin
            next_r.mode = mode_now;
            next_r.latch_prev = latch_agreed;
            case (mode_now)
                MODE_SERIAL:
                begin
                    if (latch_rise && frame_match)
                    begin
                        next_r.atten = link.word[STPATT_ATT_POS +: STPATT_STEP_W];
                        next_r.spare = link.word[STPATT_SPARE_POS];
                        next_r.addr = link.word[STPATT_ADDR_POS +: STPATT_ADDR_W];
                    end
                end
                MODE_DIRECT:
                begin
                    next_r.atten = step_agreed;
                    next_r.spare = 1'h0;
                end
                MODE_LATCHED:
                begin
                    next_r.atten = r.atten;
                end
                default:
                begin
                    next_r = r;
                end
            endcase
            if (!sel_agreed && latch_rise)
            begin
                next_r.atten = step_agreed;
                next_r.spare = 1'h0;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            r.mode <= MODE_SERIAL;
            r.latch_prev <= STPATT_RST_LATCH;
            r.atten <= STPATT_RST_ATTEN;
            r.spare <= STPATT_RST_SPARE;
            r.addr <= STPATT_RST_ADDR;
        end
        else
        begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // one means step in
    assign atten_state_out = r.atten;
    assign spare_step_out = r.spare;
    assign active_address_out = r.addr;
    assign serial_mode_out = (r.mode == MODE_SERIAL);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    reset_max_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            $past(sys_rst_in) |-> (r.atten == 7'h7f && r.addr == 3'h0 && !r.spare))
        else $error("State after reset is not maximum attenuation");

    mode_select_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            clk_en_in |=> (serial_mode_out == $past(sel_agreed)))
        else $error("Mode does not follow the select pin");

    serial_load_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            (clk_en_in && sel_agreed && latch_rise && frame_match)
            |=> (r.atten == $past(link.word[6:0])
                && r.addr == $past(strap_agreed)))
        else $error("Matching serial frame was not applied");

    addr_miss_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            (clk_en_in && sel_agreed && latch_rise && !frame_match)
            |=> $stable(r.atten) && $stable(r.addr))
        else $error("Mismatched frame changed the state");

    serial_quiet_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            (clk_en_in && sel_agreed && !latch_rise) |=> $stable(r.atten))
        else $error("State changed without a strobe");

    direct_follow_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            (clk_en_in && !sel_agreed && latch_agreed)
            |=> (atten_state_out == $past(step_agreed)))
        else $error("Direct mode did not follow the step pins");

    latched_hold_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            (clk_en_in && !sel_agreed && !latch_agreed) |=> $stable(r.atten))
        else $error("Latched mode moved while the strobe was low");

    latched_load_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            (clk_en_in && !sel_agreed && latch_rise)
            |=> (r.atten == $past(step_agreed)))
        else $error("Strobe edge did not load the step pins");

    freeze_state_a:
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            !clk_en_in |=> $stable(r))
        else $error("State moved with the clock enable low");

endmodule

/* include/stpatt_pkg.sv */
// Shared constants and types of the step attenuator control block
package stpatt_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int STPATT_SHIFT_W = 16;
    localparam int STPATT_STEP_W = 7;
    localparam int STPATT_ADDR_W = 3;

    // ----------------------------------------
    // Serial frame field positions
    // ----------------------------------------
    localparam int STPATT_ATT_POS = 0;
    localparam int STPATT_SPARE_POS = 7;
    localparam int STPATT_ADDR_POS = 8;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [6:0] STPATT_RST_ATTEN = 7'h7f;
    localparam logic STPATT_RST_SPARE = 1'h0;
    localparam logic [2:0] STPATT_RST_ADDR = 3'h0;
    localparam logic STPATT_RST_SELECT = 1'h1;
    localparam logic STPATT_RST_LATCH = 1'h1;

    // ----------------------------------------
    // Operating modes
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_SERIAL,
        MODE_DIRECT,
        MODE_LATCHED
    } stpatt_mode_t;

endpackage

/* include/stpatt_link_if.sv */
// Carrier of the serial shift word from the link domain to the system domain
`timescale 1ns/100ps
interface stpatt_link_if;
    logic [15:0] word;
    logic [15:0] word_prev;

    modport src (
        output word,
        output word_prev
    );

    modport dst (
        input word,
        input word_prev
    );
endinterface

/* hdl/stpatt_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module stpatt_sync
    import stpatt_pkg::*;
#(
    parameter int W = 12,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] agreed_out
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } stpatt_sync_t;

    stpatt_sync_t r;
    stpatt_sync_t next_r;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        next_r = r;
        if (clk_en_in)
        begin
            next_r.s1 = async_in;
            next_r.s2 = r.s1;
            next_r.s3 = r.s2;
            // A bit changes only when stages two and three agree
            next_r.val = (r.s2 & ~(r.s2 ^ r.s3)) | (r.val & (r.s2 ^ r.s3));
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            r <= {4{RST_VAL}};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign agreed_out = r.val;

endmodule

/* hdl/stpatt_shift.sv */
// Serial shift register clocked by the bus clock
`timescale 1ns/100ps
module stpatt_shift
    import stpatt_pkg::*;
(
    input wire logic ser_clk_in,
    input wire logic latch_strobe_in,
    input wire logic ser_data_in,
    stpatt_link_if.src link
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] word;
    } stpatt_shift_t;

    stpatt_shift_t r;
    stpatt_shift_t next_r;

    always_comb
    begin
        next_r = r;
        if (!latch_strobe_in)
        begin
            // first bit ends at stage zero
            next_r.word = {ser_data_in, r.word[15:1]};
        end
    end

    always_ff @(posedge ser_clk_in)
    begin
        r <= next_r;
    end

    assign link.word = r.word;
    assign link.word_prev = r.word;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    shift_hold_a:
        assert property (@(posedge ser_clk_in) disable iff (1'b0)
            latch_strobe_in |=> $stable(r.word))
        else $error("Shift register moved while the strobe was high");

    shift_step_a:
        assert property (@(posedge ser_clk_in) disable iff (1'b0)
            !latch_strobe_in |=> r.word[14:0] === $past(r.word[15:1]))
        else $error("Shift register did not move one stage down");

endmodule

/* bench/stpatt_host.sv */
// Host controller model driving the serial pins and the strobe
`timescale 1ns/100ps
module stpatt_host
(
    output logic ser_clk_out,
    output logic ser_data_out,
    output logic latch_strobe_out
);
    initial
    begin
        ser_clk_out = 1'h0;
        ser_data_out = 1'h1;
        latch_strobe_out = 1'h1;
        #0.7;
    end

    task automatic send_frame(input logic [2:0] addr, input logic [6:0] att,
                              input logic hold_high);
        logic [15:0] frame;
        frame = {5'($urandom), addr, 1'h0, att};
        latch_strobe_out = hold_high;
        #14;
        for (int i = 0; i < 16; i++)
        begin
            ser_data_out = frame[i];
            #3 ser_clk_out = 1'h1;
            #3 ser_clk_out = 1'h0;
        end
        // Data line is driven back to its idle high level
        ser_data_out = 1'h1;
        #15 latch_strobe_out = 1'h1;
        #20;
    endtask

    task automatic set_strobe(input logic v);
        latch_strobe_out = v;
        #20;
    endtask
endmodule

/* bench/tb.sv */
// Self-checking bench of the step attenuator control block
`timescale 1ns/100ps
`define CHK(e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: exp %h got %h", $time, e, a); end end
module tb
    import stpatt_pkg::*;
;
    logic clk_sys_in;
    logic sys_rst_in;
    logic clk_en_in;
    logic ser_clk;
    logic ser_data;
    logic strobe;
    logic interface_select_in;
    logic [6:0] step_control_bits_in;
    logic [2:0] board_address_pins_in;
    logic [6:0] atten_state_out;
    logic spare_step_out;
    logic [2:0] active_address_out;
    logic serial_mode_out;
    logic [11:0] exp_q[$];
    logic [11:0] exp_now;
    logic [11:0] exp_v;
    logic [11:0] got;
    logic [6:0] att;
    event chk_ev;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;

    stpatt_host stpatt_host_inst (
        .ser_clk_out(ser_clk),
        .ser_data_out(ser_data),
        .latch_strobe_out(strobe)
    );

    stpatt_top stpatt_top_inst (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .ser_clk_in(ser_clk),
        .ser_data_in(ser_data),
        .latch_strobe_in(strobe),
        .interface_select_in(interface_select_in),
        .step_control_bits_in(step_control_bits_in),
        .board_address_pins_in(board_address_pins_in),
        .atten_state_out(atten_state_out),
        .spare_step_out(spare_step_out),
        .active_address_out(active_address_out),
        .serial_mode_out(serial_mode_out)
    );

    // ----------------------------------------
    // Clock, timeout and closing report
    // ----------------------------------------
    initial
    begin
        clk_sys_in = 1'h0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Monitor: oldest note against the outputs
    // ----------------------------------------
    initial
    forever
    begin
        @(chk_ev);
        got = {serial_mode_out, spare_step_out, active_address_out, atten_state_out};
        exp_v = exp_q.pop_front();
        `CHK(exp_v, got)
    end

    task automatic expect_state();
        repeat (8) @(posedge clk_sys_in);
        #1;
        exp_q.push_back(exp_now);
        ->chk_ev;
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        clk_en_in = 1'h1;
        sys_rst_in = 1'h1;
        interface_select_in = 1'h1;
        step_control_bits_in = 7'h00;
        board_address_pins_in = 3'h0;
        void'($urandom(6917));
        repeat (8) @(posedge clk_sys_in);
        #1 sys_rst_in = 1'h0;
        exp_now = {1'h1, STPATT_RST_SPARE, STPATT_RST_ADDR, STPATT_RST_ATTEN};
        expect_state();
        $display("test reset done");
        for (int a = 0; a < 8; a++)
        begin
            board_address_pins_in = 3'(a);
            step_control_bits_in = 7'($urandom);
            att = 7'($urandom);
            stpatt_host_inst.send_frame(3'(a), att, 1'h0);
            exp_now[9:0] = {3'(a), att};
            expect_state();
            stpatt_host_inst.send_frame(3'(a) ^ 3'(1 + $urandom_range(6)), ~att, 1'h0);
            expect_state();
        end
        $display("test serial addresses done");
        stpatt_host_inst.send_frame(~board_address_pins_in, 7'h00, 1'h0);
        stpatt_host_inst.send_frame(board_address_pins_in, ~exp_now[6:0], 1'h1);
        stpatt_host_inst.set_strobe(1'h0);
        stpatt_host_inst.set_strobe(1'h1);
        expect_state();
        $display("test strobe high shift done");
        clk_en_in = 1'h0;
        att = ~exp_now[6:0];
        stpatt_host_inst.send_frame(board_address_pins_in, att, 1'h0);
        expect_state();
        clk_en_in = 1'h1;
        stpatt_host_inst.set_strobe(1'h0);
        stpatt_host_inst.set_strobe(1'h1);
        exp_now[9:0] = {board_address_pins_in, att};
        expect_state();
        $display("test clock enable done");
        interface_select_in = 1'h0;
        exp_now = {2'h0, exp_now[9:7], step_control_bits_in};
        expect_state();
        for (int i = 0; i < 7; i++)
        begin
            step_control_bits_in = 7'h01 << i;
            exp_now[6:0] = step_control_bits_in;
            expect_state();
        end
        $display("test direct parallel done");
        repeat (20) @(posedge clk_sys_in);
        #1 stpatt_host_inst.set_strobe(1'h0);
        step_control_bits_in = ~exp_now[6:0];
        expect_state();
        stpatt_host_inst.set_strobe(1'h1);
        exp_now[6:0] = step_control_bits_in;
        expect_state();
        $display("test latched parallel done");
        interface_select_in = 1'h1;
        // mode setup before the first bus clock
        #100;
        att = 7'($urandom);
        stpatt_host_inst.send_frame(board_address_pins_in, att, 1'h0);
        exp_now = {2'h2, board_address_pins_in, att};
        expect_state();
        @(posedge clk_sys_in);
        #1 sys_rst_in = 1'h1;
        interface_select_in = 1'h0;
        step_control_bits_in = 7'h7f;
        stpatt_host_inst.set_strobe(1'h0);
        repeat (2) @(posedge clk_sys_in);
        #1 sys_rst_in = 1'h0;
        repeat (10) @(posedge clk_sys_in);
        #1 step_control_bits_in = 7'($urandom) & 7'h7e;
        exp_now = {2'h0, STPATT_RST_ADDR, STPATT_RST_ATTEN};
        expect_state();
        stpatt_host_inst.set_strobe(1'h1);
        exp_now[6:0] = step_control_bits_in;
        expect_state();
        $display("test parallel power-up done");
        repeat (2) @(posedge clk_sys_in);
        complete_run();
    end
endmodule
